/* core/fbrb_pkg.sv */
/*
  constants, field layout and state type of the fifo bus and router bridge.
  assumes one system clock and a simple indexed register port on the host side.
*/
// Notes on behaviour
// [RULE1] eight buffer access registers; a write pushes, a read pops that channel
// [RULE2] a write to a full channel is dropped, channel left unchanged
// [RULE3] a read of an empty channel returns zero and completes normally
// [RULE4] buffer data sits in the low 29 bits; top three bits read zero
// [RULE5] routing word is 53 bits, fifo word is 29 bits
// [RULE6] eight streams, stream n works on fifo channel n
// [RULE7] each stream moves fifo to routing or routing to fifo
// [RULE8] low mode uses routing bits 0-23, high 24-47; control bits 48-52 always
// [RULE9] both-values read stream pushes the lower value first
// [RULE10] with room for one word, push it and hold; no new routing request
// [RULE11] both-values write stream pops lower first, offers word once both popped
// [RULE12] host writes lower value then higher value back to back
// [RULE13] both-values read stream copies control bits into both fifo words
// [RULE14] both-values write stream takes control bits from the higher word
// [RULE15] per-stream transfer mode field selects the mapping
// [RULE16] mode 00 low, 01 high, 10 both, 11 reserved
// [RULE17] direction 0 routing to fifo, 1 fifo to routing
// [RULE18] enable field: 01 disables and resets, 10 enables; reads 00 or 11
// [RULE19] read address resets to 0x1fe; address, mode, direction writable only disabled
// [RULE20] disabled stream requests nothing and drops a partial transfer
// [RULE21] read stream stalls while fifo full; write stream holds until word accepted
package fbrb_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int NUM_CH     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 29;
  localparam int ROUTE_W    = 53;
  localparam int VAL_W      = 24;
  localparam int CTRL_W     = 5;
  localparam int ADDR_W     = 9;
  localparam int IDX_W      = 5;
  localparam int DATA_W     = 32;
  localparam int MODE_W     = 2;
  localparam int EN_W       = 2;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CTRL_LSB_FIFO  = 24;
  localparam int CTRL_LSB_ROUTE = 48;
  localparam int HI_LSB_ROUTE   = 24;
  localparam int CFG_MODE_LSB   = 16;
  localparam int CFG_DIR_BIT    = 18;

  // ***************************************************************
  // register indices
  // ***************************************************************
  localparam logic [IDX_W-1:0] IDX_BUF_BASE    = 5'h00;
  localparam logic [IDX_W-1:0] IDX_ENABLE      = 5'h08;
  localparam logic [IDX_W-1:0] IDX_RDADDR_BASE = 5'h09;
  localparam logic [IDX_W-1:0] IDX_CFG_BASE    = 5'h11;

  // ***************************************************************
  // reset values and encodings
  // ***************************************************************
  localparam logic [ADDR_W-1:0] ADDR_RESET   = 9'h1fe;
  localparam logic [EN_W-1:0]   EN_CMD_DIS   = 2'h1;
  localparam logic [EN_W-1:0]   EN_CMD_ENA   = 2'h2;
  localparam logic [EN_W-1:0]   EN_RD_ON     = 2'h3;
  localparam logic [EN_W-1:0]   EN_RD_OFF    = 2'h0;
  localparam logic [MODE_W-1:0] MODE_LOW     = 2'h0;
  localparam logic [MODE_W-1:0] MODE_HIGH    = 2'h1;
  localparam logic [MODE_W-1:0] MODE_BOTH    = 2'h2;
  localparam logic              DIR_TO_FIFO  = 1'b0;
  localparam logic              DIR_TO_ROUTE = 1'b1;

  // ***************************************************************
  // stream state
  // ***************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_PART, ST_FULL} fbrb_state_t;

endpackage

/* core/fbrb_fifo.sv */
/*
  one fifo channel: parameterised width and depth, valid/ready on both sides.
  assumes the caller holds in_data while in_valid is high and not taken.
*/
`timescale 1ns/1ps
module fbrb_fifo #(
  parameter int WIDTH = fbrb_pkg::FIFO_W,
  parameter int DEPTH = fbrb_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    wr_ptr_nxt;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW-1:0]    rd_ptr_nxt;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + PW'(1);
  endfunction

  assign in_ready_out  = (cnt_r != CW'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    mem_nxt    = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cnt_nxt    = cnt_r;
    if (push) begin
      mem_nxt[wr_ptr_r] = in_data_in;
      wr_ptr_nxt        = next_ptr(wr_ptr_r);
    end
    if (pop) begin
      rd_ptr_nxt = next_ptr(rd_ptr_r);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      mem_r    <= mem_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

endmodule

/* core/fbrb_top.sv */
/*
  host buffer access port, eight fifo channels and the fifo to routing bridge.
  assumes the routing network runs on the same clock and uses valid/ready.
*/
`timescale 1ns/1ps
module fbrb_top (
  // clock and reset
  input  wire logic                                             clk_sys_in,
  input  wire logic                                             rst_b_in,
  // host register port
  input  wire logic                                             reg_wr_in,
  input  wire logic                                             reg_rd_in,
  input  wire logic [fbrb_pkg::IDX_W-1:0]                       reg_idx_in,
  input  wire logic [fbrb_pkg::DATA_W-1:0]                      reg_wdata_in,
  output logic      [fbrb_pkg::DATA_W-1:0]                      reg_rdata_out,
  output logic                                                  reg_rvalid_out,
  // routing network to fifo
  output logic      [fbrb_pkg::NUM_CH-1:0]                      rt_rd_ready_out,
  output logic      [fbrb_pkg::NUM_CH-1:0][fbrb_pkg::ADDR_W-1:0]  rt_rd_addr_out,
  input  wire logic [fbrb_pkg::NUM_CH-1:0]                      rt_rd_valid_in,
  input  wire logic [fbrb_pkg::NUM_CH-1:0][fbrb_pkg::ROUTE_W-1:0] rt_rd_data_in,
  // fifo to routing network
  output logic      [fbrb_pkg::NUM_CH-1:0]                      rt_wr_valid_out,
  output logic      [fbrb_pkg::NUM_CH-1:0][fbrb_pkg::ROUTE_W-1:0] rt_wr_data_out,
  input  wire logic [fbrb_pkg::NUM_CH-1:0]                      rt_wr_ready_in
);

  localparam int NCH = fbrb_pkg::NUM_CH;
  localparam int IW  = fbrb_pkg::IDX_W;
  localparam int FW  = fbrb_pkg::FIFO_W;
  localparam int RW  = fbrb_pkg::ROUTE_W;
  localparam int VW  = fbrb_pkg::VAL_W;
  localparam int CTW = fbrb_pkg::CTRL_W;
  localparam int AW  = fbrb_pkg::ADDR_W;
  localparam int MW  = fbrb_pkg::MODE_W;
  localparam int EW  = fbrb_pkg::EN_W;

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic [NCH-1:0]                en_r;
  logic [NCH-1:0]                en_nxt;
  logic [NCH-1:0]                dir_r;
  logic [NCH-1:0]                dir_nxt;
  logic [NCH-1:0][MW-1:0]        mode_r;
  logic [NCH-1:0][MW-1:0]        mode_nxt;
  logic [NCH-1:0][AW-1:0]        addr_r;
  logic [NCH-1:0][AW-1:0]        addr_nxt;
  fbrb_pkg::fbrb_state_t         state_r   [NCH];
  fbrb_pkg::fbrb_state_t         state_nxt [NCH];
  logic [NCH-1:0][RW-1:0]        hold_r;
  logic [NCH-1:0][RW-1:0]        hold_nxt;
  logic [fbrb_pkg::DATA_W-1:0]   rdata_r;
  logic [fbrb_pkg::DATA_W-1:0]   rdata_nxt;
  logic                          rvalid_r;
  logic                          rvalid_nxt;
  logic [NCH-1:0]                bus_push;
  logic [NCH-1:0]                bus_pop;
  logic [NCH-1:0]                dis_cmd;
  logic [NCH-1:0]                st_push;
  logic [NCH-1:0]                st_pop;
  logic [NCH-1:0][FW-1:0]        st_word;
  logic [NCH-1:0]                f_in_valid;
  logic [NCH-1:0]                f_in_ready;
  logic [NCH-1:0][FW-1:0]        f_in_data;
  logic [NCH-1:0]                f_out_valid;
  logic [NCH-1:0]                f_out_ready;
  logic [NCH-1:0][FW-1:0]        f_out_data;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic is_idx(input logic [IW-1:0] idx,
                                  input logic [IW-1:0] base,
                                  input int            ch);
    return idx == (base + IW'(ch));
  endfunction

  // one routing value plus control bits into a fifo word
  function automatic logic [FW-1:0] to_fifo(input logic [RW-1:0] w,
                                            input logic          sel_hi);
    logic [VW-1:0] v;
    v = sel_hi ? w[fbrb_pkg::HI_LSB_ROUTE +: VW] : w[VW-1:0];
    return {w[fbrb_pkg::CTRL_LSB_ROUTE +: CTW], v};                 // [RULE8] [RULE13]
  endfunction

  // one fifo word into a routing word, other value zero
  function automatic logic [RW-1:0] to_route(input logic [FW-1:0] w,
                                             input logic          sel_hi);
    logic [RW-1:0] r;
    r = '0;
    r[fbrb_pkg::CTRL_LSB_ROUTE +: CTW] = w[fbrb_pkg::CTRL_LSB_FIFO +: CTW]; // [RULE8]
    if (sel_hi) begin
      r[fbrb_pkg::HI_LSB_ROUTE +: VW] = w[VW-1:0];
    end else begin
      r[VW-1:0] = w[VW-1:0];
    end
    return r;
  endfunction

  // ***************************************************************
  // host access decode
  // ***************************************************************
  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      bus_push[ch] = reg_wr_in && is_idx(reg_idx_in, fbrb_pkg::IDX_BUF_BASE, ch); // [RULE1]
      bus_pop[ch]  = reg_rd_in && is_idx(reg_idx_in, fbrb_pkg::IDX_BUF_BASE, ch); // [RULE1]
      dis_cmd[ch]  = reg_wr_in && (reg_idx_in == fbrb_pkg::IDX_ENABLE) &&
                     (reg_wdata_in[EW*ch +: EW] == fbrb_pkg::EN_CMD_DIS);
    end
  end

  // ***************************************************************
  // channel fifos
  // ***************************************************************
  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      // host access wins the port, the stream waits a cycle
      f_in_valid[ch]  = bus_push[ch] | st_push[ch];                 // [RULE2]
      f_in_data[ch]   = bus_push[ch] ? reg_wdata_in[FW-1:0] : st_word[ch];
      f_out_ready[ch] = bus_pop[ch] | st_pop[ch];
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    fbrb_fifo #(
      .WIDTH (FW),
      .DEPTH (fbrb_pkg::FIFO_DEPTH)
    ) u_fifo (
      .clk_sys_in    (clk_sys_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (f_in_valid[g]),
      .in_ready_out  (f_in_ready[g]),
      .in_data_in    (f_in_data[g]),
      .out_valid_out (f_out_valid[g]),
      .out_ready_in  (f_out_ready[g]),
      .out_data_out  (f_out_data[g])
    );                                                               // [RULE6]
  end

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  always_comb begin
    en_nxt   = en_r;
    dir_nxt  = dir_r;
    mode_nxt = mode_r;
    addr_nxt = addr_r;
    if (reg_wr_in) begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (reg_idx_in == fbrb_pkg::IDX_ENABLE) begin
          unique case (reg_wdata_in[EW*ch +: EW])
            fbrb_pkg::EN_CMD_DIS: en_nxt[ch] = 1'b0;                 // [RULE18]
            fbrb_pkg::EN_CMD_ENA: en_nxt[ch] = 1'b1;                 // [RULE18]
            default:              en_nxt[ch] = en_r[ch];
          endcase
        end
        if (!en_r[ch] && is_idx(reg_idx_in, fbrb_pkg::IDX_RDADDR_BASE, ch)) begin
          addr_nxt[ch] = reg_wdata_in[AW-1:0];                       // [RULE19]
        end
        if (!en_r[ch] && is_idx(reg_idx_in, fbrb_pkg::IDX_CFG_BASE, ch)) begin
          mode_nxt[ch] = reg_wdata_in[fbrb_pkg::CFG_MODE_LSB +: MW]; // [RULE15] [RULE19]
          dir_nxt[ch]  = reg_wdata_in[fbrb_pkg::CFG_DIR_BIT];        // [RULE17] [RULE19]
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_r   <= '0;
      dir_r  <= '0;
      mode_r <= '0;
      addr_r <= {NCH{fbrb_pkg::ADDR_RESET}};                         // [RULE19]
    end else begin
      en_r   <= en_nxt;
      dir_r  <= dir_nxt;
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ***************************************************************
  // read data
  // ***************************************************************
  always_comb begin
    rdata_nxt  = '0;
    rvalid_nxt = reg_rd_in;
    if (reg_rd_in) begin
      if (reg_idx_in == fbrb_pkg::IDX_ENABLE) begin
        for (int ch = 0; ch < NCH; ch++) begin
          rdata_nxt[EW*ch +: EW] = en_r[ch] ? fbrb_pkg::EN_RD_ON
                                            : fbrb_pkg::EN_RD_OFF;    // [RULE18]
        end
      end
      for (int ch = 0; ch < NCH; ch++) begin
        if (is_idx(reg_idx_in, fbrb_pkg::IDX_BUF_BASE, ch) && f_out_valid[ch]) begin
          rdata_nxt[FW-1:0] = f_out_data[ch];                        // [RULE3] [RULE4]
        end
        if (is_idx(reg_idx_in, fbrb_pkg::IDX_RDADDR_BASE, ch)) begin
          rdata_nxt[AW-1:0] = addr_r[ch];
        end
        if (is_idx(reg_idx_in, fbrb_pkg::IDX_CFG_BASE, ch)) begin
          rdata_nxt[fbrb_pkg::CFG_MODE_LSB +: MW] = mode_r[ch];
          rdata_nxt[fbrb_pkg::CFG_DIR_BIT]        = dir_r[ch];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_out  = rdata_r;
  assign reg_rvalid_out = rvalid_r;

  // ***************************************************************
  // stream engines
  // ***************************************************************
  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      state_nxt[ch]       = state_r[ch];
      hold_nxt[ch]        = hold_r[ch];
      st_push[ch]         = 1'b0;
      st_pop[ch]          = 1'b0;
      st_word[ch]         = '0;
      rt_rd_ready_out[ch] = 1'b0;
      rt_wr_valid_out[ch] = 1'b0;
      if (!en_r[ch]) begin
        state_nxt[ch] = fbrb_pkg::ST_IDLE;                           // [RULE20]
        hold_nxt[ch]  = '0;
      end else if (dir_r[ch] == fbrb_pkg::DIR_TO_FIFO) begin         // [RULE7]
        unique case (state_r[ch])
          fbrb_pkg::ST_IDLE: begin
            rt_rd_ready_out[ch] = f_in_ready[ch];                    // [RULE21]
            if (rt_rd_valid_in[ch] && f_in_ready[ch]) begin
              hold_nxt[ch]  = rt_rd_data_in[ch];                     // [RULE5]
              state_nxt[ch] = fbrb_pkg::ST_FULL;
            end
          end
          fbrb_pkg::ST_FULL: begin
            st_push[ch] = 1'b1;
            st_word[ch] = to_fifo(hold_r[ch], mode_r[ch] == fbrb_pkg::MODE_HIGH); // [RULE9]
            if (f_in_ready[ch] && !bus_push[ch]) begin
              state_nxt[ch] = (mode_r[ch] == fbrb_pkg::MODE_BOTH) ?
                              fbrb_pkg::ST_PART : fbrb_pkg::ST_IDLE; // [RULE16]
            end
          end
          fbrb_pkg::ST_PART: begin
            // higher value waits here for room, no new request meanwhile
            st_push[ch] = 1'b1;
            st_word[ch] = to_fifo(hold_r[ch], 1'b1);                 // [RULE10] [RULE13]
            if (f_in_ready[ch] && !bus_push[ch]) begin
              state_nxt[ch] = fbrb_pkg::ST_IDLE;
            end
          end
          default: state_nxt[ch] = fbrb_pkg::ST_IDLE;
        endcase
      end else begin
        unique case (state_r[ch])
          fbrb_pkg::ST_IDLE: begin
            st_pop[ch] = 1'b1;
            if (f_out_valid[ch] && !bus_pop[ch]) begin
              if (mode_r[ch] == fbrb_pkg::MODE_BOTH) begin
                hold_nxt[ch]  = to_route(f_out_data[ch], 1'b0);      // [RULE11]
                state_nxt[ch] = fbrb_pkg::ST_PART;
              end else begin
                hold_nxt[ch]  = to_route(f_out_data[ch],
                                         mode_r[ch] == fbrb_pkg::MODE_HIGH); // [RULE16]
                state_nxt[ch] = fbrb_pkg::ST_FULL;
              end
            end
          end
          fbrb_pkg::ST_PART: begin
            st_pop[ch] = 1'b1;                                       // [RULE11]
            if (f_out_valid[ch] && !bus_pop[ch]) begin
              hold_nxt[ch] = {f_out_data[ch][fbrb_pkg::CTRL_LSB_FIFO +: CTW],
                              f_out_data[ch][VW-1:0],
                              hold_r[ch][VW-1:0]};                   // [RULE14]
              state_nxt[ch] = fbrb_pkg::ST_FULL;
            end
          end
          fbrb_pkg::ST_FULL: begin
            rt_wr_valid_out[ch] = 1'b1;                              // [RULE21]
            if (rt_wr_ready_in[ch]) begin
              state_nxt[ch] = fbrb_pkg::ST_IDLE;
            end
          end
          default: state_nxt[ch] = fbrb_pkg::ST_IDLE;
        endcase
      end
      if (dis_cmd[ch]) begin
        state_nxt[ch] = fbrb_pkg::ST_IDLE;                           // [RULE18] [RULE20]
        hold_nxt[ch]  = '0;
        st_push[ch]         = 1'b0;                                  // [RULE20]
        st_pop[ch]          = 1'b0;                                  // [RULE20]
        rt_rd_ready_out[ch] = 1'b0;                                  // [RULE20]
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int ch = 0; ch < NCH; ch++) begin
        state_r[ch] <= fbrb_pkg::ST_IDLE;
      end
      hold_r <= '0;
    end else begin
      state_r <= state_nxt;
      hold_r  <= hold_nxt;
    end
  end

  assign rt_rd_addr_out = addr_r;
  assign rt_wr_data_out = hold_r;

endmodule

/* bench/fbrb_chk.sv */
/*
  port checker for the fifo bus and router bridge top, bound after the module.
  assumes one clock domain and the valid/ready routing ports.
*/
`timescale 1ns/1ps
module fbrb_chk (
  // clock and reset
  input wire logic             clk_sys_in,
  input wire logic             rst_b_in,
  // host register port
  input wire logic             reg_wr_in,
  input wire logic             reg_rd_in,
  input wire logic [4:0]       reg_idx_in,
  input wire logic [31:0]      reg_wdata_in,
  input wire logic [31:0]      reg_rdata_out,
  input wire logic             reg_rvalid_out,
  // routing ports
  input wire logic [7:0]       rt_rd_ready_out,
  input wire logic [7:0][8:0]  rt_rd_addr_out,
  input wire logic [7:0]       rt_rd_valid_in,
  input wire logic [7:0]       rt_wr_valid_out,
  input wire logic [7:0][52:0] rt_wr_data_out,
  input wire logic [7:0]       rt_wr_ready_in
);
  // ********************
  // assertions
  // ********************
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  property p_rv; reg_rd_in |=> reg_rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_nrv; reg_rvalid_out |-> $past(reg_rd_in); endproperty
  a_nrv: assert property (p_nrv) else $error("answer without read");
  property p_top; reg_rvalid_out |-> reg_rdata_out[31:29] == 3'h0; endproperty
  a_top: assert property (p_top) else $error("top bits not zero");
  property p_zero; !reg_rvalid_out |-> reg_rdata_out == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("idle read data not zero");
  property p_hold; rt_wr_valid_out[4] && !rt_wr_ready_in[4] && !reg_wr_in
    |=> rt_wr_valid_out[4] && $stable(rt_wr_data_out[4]); endproperty
  a_hold: assert property (p_hold) else $error("offer dropped");
  property p_take; |(rt_rd_valid_in & rt_rd_ready_out)
    |=> (rt_rd_ready_out & $past(rt_rd_valid_in & rt_rd_ready_out)) == 8'h0; endproperty
  a_take: assert property (p_take) else $error("ready after take");
  property p_dis; reg_wr_in && reg_idx_in == 5'h08 && reg_wdata_in[3:2] == 2'h1
    |=> !rt_rd_ready_out[1] && !rt_wr_valid_out[1]; endproperty
  a_dis: assert property (p_dis) else $error("disabled stream active");
  property p_addr; !$past(reg_wr_in) |-> $stable(rt_rd_addr_out); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
endmodule
bind fbrb_top fbrb_chk u_chk (.clk_sys_in, .rst_b_in, .reg_wr_in, .reg_rd_in, .reg_idx_in,
  .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .rt_rd_ready_out, .rt_rd_addr_out,
  .rt_rd_valid_in, .rt_wr_valid_out, .rt_wr_data_out, .rt_wr_ready_in);

/* bench/fbrb_rt_model.sv */
/*
  routing network model: offers words to read streams, takes words from write streams.
  assumes the bench calls send and sets stall only at the falling edge.
*/
`timescale 1ns/1ps
module fbrb_rt_model (
  // clock
  input wire logic              clk_sys_in,
  // routing to fifo
  input wire logic [7:0]        rd_ready_in,
  output logic     [7:0]        rd_valid_out,
  output logic     [7:0][52:0]  rd_data_out,
  // fifo to routing
  input wire logic [7:0]        wr_valid_in,
  input wire logic [7:0][52:0]  wr_data_in,
  output logic     [7:0]        wr_ready_out
);
  // ********************
  // word offer and capture
  // ********************
  logic [7:0]  stall = 8'hff;
  logic [52:0] got[$];
  initial begin
    rd_valid_out = 8'h0;
    rd_data_out = '0;
  end
  assign wr_ready_out = ~stall;
  always @(posedge clk_sys_in) begin
    for (int c = 0; c < 8; c++) if (wr_valid_in[c] && wr_ready_out[c]) got.push_back(wr_data_in[c]);
  end
  // one 53-bit word held until taken, then line shows the inverse
  task automatic send(input int c, input logic [52:0] w);
    @(negedge clk_sys_in);
    rd_valid_out[c] = 1'b1;
    rd_data_out[c] = w;
    while (!rd_ready_in[c]) @(negedge clk_sys_in);
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rd_valid_out[c] = 1'b0;
    rd_data_out[c] = ~w;
  endtask
endmodule

/* bench/fbrb_tb_top.sv */
/*
  self-checking bench for the fifo bus and router bridge.
  assumes the register indices and field layout of the package notes.
*/
`timescale 1ns/1ps
module fbrb_tb_top;
  // ********************
  // signals and instances
  // ********************
  logic             clk_sys_in = 1'b0;
  logic             rst_b_in = 1'b0;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [4:0]       reg_idx = 5'h0;
  logic [31:0]      reg_wdata = 32'h0;
  logic [31:0]      reg_rdata;
  logic             reg_rvalid;
  logic [7:0]       rt_rd_ready, rt_rd_valid, rt_wr_valid, rt_wr_ready;
  logic [7:0][8:0]  rt_rd_addr;
  logic [7:0][52:0] rt_rd_data, rt_wr_data;
  int               fails = 0, n_checks = 0, cyc = 0;
  fbrb_top dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_idx_in(reg_idx), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid), .rt_rd_ready_out(rt_rd_ready),
    .rt_rd_addr_out(rt_rd_addr), .rt_rd_valid_in(rt_rd_valid), .rt_rd_data_in(rt_rd_data),
    .rt_wr_valid_out(rt_wr_valid), .rt_wr_data_out(rt_wr_data), .rt_wr_ready_in(rt_wr_ready));
  fbrb_rt_model rt (.clk_sys_in(clk_sys_in), .rd_ready_in(rt_rd_ready),
    .rd_valid_out(rt_rd_valid), .rd_data_out(rt_rd_data), .wr_valid_in(rt_wr_valid),
    .wr_data_in(rt_wr_data), .wr_ready_out(rt_wr_ready));
  always #10 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end
  // ********************
  // shared tasks
  // ********************
  task automatic print_verdict();
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [52:0] seen, input logic [52:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    @(negedge clk_sys_in);
    reg_wr = 1'b1;
    reg_idx = i;
    reg_wdata = d;
    @(negedge clk_sys_in);
    reg_wr = 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [4:0] i, input logic [31:0] e);
    @(negedge clk_sys_in);
    reg_rd = 1'b1;
    reg_idx = i;
    @(negedge clk_sys_in);
    reg_rd = 1'b0;
    check(nm, (reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxxxxxx, e);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    rchk("enable", 5'h08, 32'h0);
    rchk("rd addr", 5'h09, 32'h1fe);
    rchk("cfg", 5'h11, 32'h0);
    rchk("unmapped", 5'h1f, 32'h0);
    check("addr out", rt_rd_addr[0], 9'h1fe);
  endtask
  task automatic t_full();
    for (int k = 0; k < 9; k++) wr(5'h03, 32'hfedcba90 + k);
    for (int k = 0; k < 8; k++) rchk("buf", 5'h03, 32'h1edcba90 + k);
    rchk("empty", 5'h03, 32'h0);
  endtask
  task automatic t_rdstream();
    for (int m = 0; m < 4; m++) begin
      wr(5'h12, m << 16);
      wr(5'h08, 32'h8);
      rchk("en on", 5'h08, 32'hc);
      wr(5'h0a, 32'h55);
      rt.send(1, {5'h15, 24'hbbbbbb, 24'haaaaaa});
      repeat (2) @(negedge clk_sys_in);
      if (m == 2) rchk("both lo", 5'h01, {8'h15, 24'haaaaaa});
      rchk("val", 5'h01, {8'h15, (m == 1 || m == 2) ? 24'hbbbbbb : 24'haaaaaa});
      rchk("drained", 5'h01, 32'h0);
      rchk("addr kept", 5'h0a, 32'h1fe);
      wr(5'h08, 32'h4);
      rchk("en off", 5'h08, 32'h0);
    end
    wr(5'h0a, 32'h55);
    check("addr set", rt_rd_addr[1], 9'h055);
  endtask
  task automatic t_hold();
    wr(5'h13, 32'h20000);
    for (int k = 0; k < 7; k++) wr(5'h02, k);
    wr(5'h08, 32'h20);
    rt.send(2, {5'h0a, 24'h666666, 24'h555555});
    repeat (4) @(negedge clk_sys_in);
    check("ready held", rt_rd_ready[2], 1'b0);
    for (int k = 0; k < 7; k++) rchk("pre", 5'h02, k);
    rchk("part lo", 5'h02, {8'h0a, 24'h555555});
    rchk("part hi", 5'h02, {8'h0a, 24'h666666});
    wr(5'h08, 32'h10);
  endtask
  task automatic t_wrstream();
    logic [52:0] e[3];
    e = '{{5'h03, 24'h0, 24'h111111}, {5'h03, 24'h111111, 24'h0},
          {5'h1c, 24'h222222, 24'h111111}};
    for (int m = 0; m < 3; m++) begin
      wr(5'h15, 32'h40000 | (m << 16));
      wr(5'h04, {8'h03, 24'h111111});
      wr(5'h08, 32'h200);
      repeat (4) @(negedge clk_sys_in);
      check("early offer", rt_wr_valid[4], m != 2);
      if (m == 2) wr(5'h04, {8'h1c, 24'h222222});
      repeat (4) @(negedge clk_sys_in);
      check("offer", rt_wr_valid[4], 1'b1);
      rt.stall[4] = 1'b0;
      for (int n = 0; n < 20 && rt.got.size() == 0; n++) @(negedge clk_sys_in);
      rt.stall[4] = 1'b1;
      check("word", rt.got.pop_front(), e[m]);
      wr(5'h08, 32'h100);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    t_reset();
    t_full();
    t_rdstream();
    t_hold();
    t_wrstream();
    print_verdict();
  end
endmodule
